/* hw/irq_front_end.sv */
/*
 Interrupt source front end: fault sources, six filtered external
 interrupt pins and their registers on an AXI4-Lite slave.
 Assumes pins synchronous to SYS_CLK and LOW_FREQ_TICK one cycle per
 low-frequency clock period.
*/
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module irq_front_end #(
   parameter int          ADDR_W  = 12,
   parameter logic [15:0] RAM_TOP = 16'h083F
) (
   // Clock and reset
   input  wire logic              SYS_CLK,
   input  wire logic              ARST_N,
   // AXI4-Lite write address and data
   input  wire logic [ADDR_W-1:0] AWADDR,
   input  wire logic              AWVALID,
   output var  logic              AWREADY,
   input  wire logic [31:0]       WDATA,
   input  wire logic [3:0]        WSTRB,
   input  wire logic              WVALID,
   output var  logic              WREADY,
   // AXI4-Lite write response
   output var  logic [1:0]        BRESP,
   output var  logic              BVALID,
   input  wire logic              BREADY,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] ARADDR,
   input  wire logic              ARVALID,
   output var  logic              ARREADY,
   output var  logic [31:0]       RDATA,
   output var  logic [1:0]        RRESP,
   output var  logic              RVALID,
   input  wire logic              RREADY,
   // Fetch side of the core
   input  wire logic              FETCH_VALID,
   input  wire logic [15:0]       FETCH_ADDR,
   input  wire logic [7:0]        FETCH_DATA,
   input  wire logic              FETCH_MAPPED,
   input  wire logic              UNDEF_EXEC,
   // Fault interrupts
   output var  logic [7:0]        OPCODE_OUT,
   output var  logic              SW_TRAP_IRQ,
   output var  logic              ILLEGAL_OPCODE_IRQ,
   output var  logic              FETCH_VIOL_IRQ,
   output var  logic              TRAP_RESET_OUT,
   // External interrupt pins
   input  wire logic [5:0]        EXT_PIN,
   input  wire logic              LOW_FREQ_TICK,
   input  wire logic [5:0]        EXT_IRQ_ACK,
   output var  logic [5:0]        EXT_IRQ_REQ,
   output var  logic              PIN_ZERO_IS_IRQ
);
   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
      $error("irq_front_end: ADDR_W must be 8 to 32");
   end

   // ****************************************************************
   // Address decode
   // ****************************************************************
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] hi;
      hi      = a >> 8;
      addr_ok = (hi == '0) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [5:0] addr_idx(input logic [ADDR_W-1:0] a);
      addr_idx = a[7:2];
   endfunction

   // ****************************************************************
   // Register state
   // ****************************************************************
   logic [7:0]        ctrl_r;
   logic [1:0]        mode_r;
   logic              wdog_r;
   logic [7:0]        en_r;
   logic [1:0]        src_r;
   logic [5:0]        latch_r;
   logic [5:0]        latch_nxt;
   logic              armed_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0]       wdata_r;
   logic              wstrb0_r;
   logic              aw_full_r;
   logic              w_full_r;

   // ****************************************************************
   // Write channel
   // ****************************************************************
   wire       aw_take = AWVALID && AWREADY;
   wire       w_take  = WVALID && WREADY;
   wire       wr_fire = aw_full_r && w_full_r && !BVALID;
   wire       b_done  = BVALID && BREADY;
   wire       wr_ok   = addr_ok(awaddr_r);
   wire [5:0] wr_idx  = addr_idx(awaddr_r);
   wire       wr_en   = wr_fire && wr_ok && wstrb0_r;
   wire [7:0] wr_byte = wdata_r[7:0];

   wire wr_ctrl  = wr_en && wr_idx == irq_fe_pkg::IDX_EXT_CTRL;
   wire wr_mode  = wr_en && wr_idx == irq_fe_pkg::IDX_MODE;
   wire wr_wdog  = wr_en && wr_idx == irq_fe_pkg::IDX_WDOG_CTRL;
   wire wr_en_r  = wr_en && wr_idx == irq_fe_pkg::IDX_ENABLE;
   wire wr_src   = wr_en && wr_idx == irq_fe_pkg::IDX_SRC_SEL;
   wire wr_latch = wr_en && wr_idx == irq_fe_pkg::IDX_LATCH;

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         AWREADY   <= 1'b1;
         WREADY    <= 1'b1;
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         awaddr_r  <= '0;
         wdata_r   <= 32'h0000_0000;
         wstrb0_r  <= 1'b0;
      end else begin
         if (aw_take) begin
            awaddr_r  <= AWADDR;
            aw_full_r <= 1'b1;
            AWREADY   <= 1'b0;
         end else if (wr_fire) begin
            aw_full_r <= 1'b0;
         end else if (b_done) begin
            AWREADY <= 1'b1;
         end
         if (w_take) begin
            wdata_r  <= WDATA;
            wstrb0_r <= WSTRB[0];
            w_full_r <= 1'b1;
            WREADY   <= 1'b0;
         end else if (wr_fire) begin
            w_full_r <= 1'b0;
         end else if (b_done) begin
            WREADY <= 1'b1;
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         BVALID <= 1'b0;
         BRESP  <= RESP_OKAY;
      end else if (wr_fire) begin
         BVALID <= 1'b1;
         BRESP  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (b_done) begin
         BVALID <= 1'b0;
      end
   end

   // ****************************************************************
   // Control registers
   // ****************************************************************
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ctrl_r <= irq_fe_pkg::CTL_RST;
         mode_r <= irq_fe_pkg::MODE_RST;
         wdog_r <= 1'b0;
         en_r   <= 8'h00;
         src_r  <= 2'h0;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= wr_byte & irq_fe_pkg::CTL_WMASK;
         end
         if (wr_mode) begin
            mode_r <= wr_byte[1:0];
         end
         if (wr_wdog) begin
            wdog_r <= wr_byte[0];
         end
         if (wr_en_r) begin
            en_r <= wr_byte & 8'hBF;
         end
         if (wr_src) begin
            src_r <= wr_byte[1:0];
         end
      end
   end

   // ****************************************************************
   // Fault sources
   // ****************************************************************
   fetch_trap #(
      .AW      (16),
      .RAM_TOP (RAM_TOP)
   ) u_trap (
      .clk           (SYS_CLK),
      .arst_n        (ARST_N),
      .fetch_valid   (FETCH_VALID),
      .fetch_addr    (FETCH_ADDR),
      .fetch_data    (FETCH_DATA),
      .mem_present   (FETCH_MAPPED),
      .undef_exec    (UNDEF_EXEC),
      .single_chip   (mode_r[irq_fe_pkg::MODE_SCHIP]),
      .trap_to_reset (wdog_r),
      .opcode        (OPCODE_OUT),
      .sw_irq        (SW_TRAP_IRQ),
      .undef_irq     (ILLEGAL_OPCODE_IRQ),
      .viol_irq      (FETCH_VIOL_IRQ),
      .viol_rst      (TRAP_RESET_OUT)
   );

   // ****************************************************************
   // Noise filter timing
   // ****************************************************************
   wire       slow     = mode_r[irq_fe_pkg::MODE_SLOW];
   wire       samp     = slow ? LOW_FREQ_TICK : 1'b1;
   wire [7:0] thr_one  = ctrl_r[irq_fe_pkg::CTL_FILT_SEL] ?
                         irq_fe_pkg::CNT_S : irq_fe_pkg::CNT_L;
   wire [7:0] thr_fast [6];
   wire [7:0] thr      [6];

   assign thr_fast[0] = irq_fe_pkg::CNT_A;
   assign thr_fast[1] = thr_one;
   assign thr_fast[2] = irq_fe_pkg::CNT_M;
   assign thr_fast[3] = irq_fe_pkg::CNT_M;
   assign thr_fast[4] = irq_fe_pkg::CNT_M;
   assign thr_fast[5] = irq_fe_pkg::CNT_A;

   wire [5:0] lvl;
   wire [5:0] rise;
   wire [5:0] fall;

   for (genvar i = 0; i < 6; i++) begin : g_flt
      assign thr[i] = slow ? irq_fe_pkg::CNT_SLOW : thr_fast[i];
      noise_filter #(
         .CNT_W (8)
      ) u_flt (
         .clk       (SYS_CLK),
         .arst_n    (ARST_N),
         .pin       (EXT_PIN[i]),
         .sample_en (samp),
         .thr       (thr[i]),
         .level     (lvl[i]),
         .rise      (rise[i]),
         .fall      (fall[i])
      );
   end

   // ****************************************************************
   // Trigger selection
   // ****************************************************************
   wire [1:0] trig4 = ctrl_r[irq_fe_pkg::CTL_TRIG4_LO +: 2];
   wire       hit4_edge = (trig4 == irq_fe_pkg::TRIG_RISE && rise[4]) ||
                          (trig4 == irq_fe_pkg::TRIG_FALL && fall[4]) ||
                          (trig4 == irq_fe_pkg::TRIG_BOTH &&
                           (rise[4] || fall[4]));
   wire       hit4_lvl  = trig4 == irq_fe_pkg::TRIG_HIGH &&
                          lvl[4] && armed_r;
   wire [5:0] set;

   assign set[0] = fall[0] && ctrl_r[irq_fe_pkg::CTL_PIN_SEL];
   assign set[1] = ctrl_r[irq_fe_pkg::CTL_ES1] ? fall[1] : rise[1];
   assign set[2] = ctrl_r[irq_fe_pkg::CTL_ES2] ? fall[2] : rise[2];
   assign set[3] = ctrl_r[irq_fe_pkg::CTL_ES3] ? fall[3] : rise[3];
   assign set[4] = (hit4_edge || hit4_lvl) && !src_r[0];
   assign set[5] = fall[5] && !src_r[1];

   // ****************************************************************
   // Interrupt latches
   // ****************************************************************
   wire [5:0] clr = EXT_IRQ_ACK | (wr_latch ? wr_byte[5:0] : 6'h00);

   // Set wins over a clear in the same cycle
   assign latch_nxt = set | (latch_r & ~clr);

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         latch_r         <= 6'h00;
         armed_r         <= 1'b0;
         EXT_IRQ_REQ     <= 6'h00;
         PIN_ZERO_IS_IRQ <= 1'b0;
      end else begin
         latch_r <= latch_nxt;
         armed_r <= armed_r | rise[4];
         EXT_IRQ_REQ <= latch_nxt & en_r[5:0] &
                        {6{en_r[irq_fe_pkg::EN_MASTER]}};
         PIN_ZERO_IS_IRQ <= ctrl_r[irq_fe_pkg::CTL_PIN_SEL];
      end
   end

   // ****************************************************************
   // Read channel
   // ****************************************************************
   wire       ar_take = ARVALID && ARREADY;
   wire       r_done  = RVALID && RREADY;
   wire       rd_ok   = addr_ok(ARADDR);
   wire [5:0] rd_idx  = addr_idx(ARADDR);
   logic [7:0] rd_byte;

   always_comb begin
      case (rd_idx)
         irq_fe_pkg::IDX_EXT_CTRL:  rd_byte = ctrl_r;
         irq_fe_pkg::IDX_MODE:      rd_byte = {6'h00, mode_r};
         irq_fe_pkg::IDX_WDOG_CTRL: rd_byte = {7'h00, wdog_r};
         irq_fe_pkg::IDX_ENABLE:    rd_byte = en_r;
         irq_fe_pkg::IDX_SRC_SEL:   rd_byte = {6'h00, src_r};
         irq_fe_pkg::IDX_LATCH:     rd_byte = {2'h0, latch_r};
         irq_fe_pkg::IDX_PIN_STAT:  rd_byte = {2'h0, lvl};
         default:                   rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ARREADY <= 1'b1;
         RVALID  <= 1'b0;
         RDATA   <= 32'h0000_0000;
         RRESP   <= RESP_OKAY;
      end else if (ar_take) begin
         ARREADY <= 1'b0;
         RVALID  <= 1'b1;
         RDATA   <= rd_ok ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         RRESP   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (r_done) begin
         ARREADY <= 1'b1;
         RVALID  <= 1'b0;
      end
   end

   // Software must disable the enables before clock or control changes
   // or the filter may produce a false edge.
endmodule
`default_nettype wire

/* common/irq_fe_pkg.sv */
/*
 Shared constants of the interrupt source front end: register indices,
 field positions, reset values and noise filter counts.
 Assumes a 32-bit AXI4-Lite register bus, one word per register index.
*/
`default_nettype none
package irq_fe_pkg;
   // ****************************************************************
   // Register indices (byte address is four times the index)
   // ****************************************************************
   localparam logic [5:0] IDX_WDOG_CTRL = 6'h34;
   localparam logic [5:0] IDX_EXT_CTRL  = 6'h37;
   localparam logic [5:0] IDX_MODE      = 6'h38;
   localparam logic [5:0] IDX_PIN_STAT  = 6'h3B;
   localparam logic [5:0] IDX_ENABLE    = 6'h3A;
   localparam logic [5:0] IDX_LATCH     = 6'h3C;
   localparam logic [5:0] IDX_SRC_SEL   = 6'h3E;
   localparam logic [5:0] IDX_LAST      = 6'h3F;
   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int         CTL_FILT_SEL  = 7;
   localparam int         CTL_PIN_SEL   = 6;
   localparam int         CTL_TRIG4_LO  = 4;
   localparam int         CTL_ES3       = 3;
   localparam int         CTL_ES2       = 2;
   localparam int         CTL_ES1       = 1;
   localparam logic [7:0] CTL_RST       = 8'h00;
   localparam logic [7:0] CTL_WMASK     = 8'hFE;
   localparam int         MODE_SLOW     = 0;
   localparam int         MODE_SCHIP    = 1;
   localparam logic [1:0] MODE_RST      = 2'h2;
   localparam int         EN_MASTER     = 7;
   localparam logic [1:0] TRIG_RISE     = 2'h0;
   localparam logic [1:0] TRIG_FALL     = 2'h1;
   localparam logic [1:0] TRIG_BOTH     = 2'h2;
   localparam logic [1:0] TRIG_HIGH     = 2'h3;
   localparam logic [7:0] TRAP_OPCODE   = 8'hFF;
   // ****************************************************************
   // Filter times in clock periods, and stable counts derived from them
   // ****************************************************************
   localparam int FC_REJ_A   = 2;
   localparam int FC_ACC_A   = 7;
   localparam int FC_REJ_L   = 63;
   localparam int FC_ACC_L   = 193;
   localparam int FC_REJ_S   = 15;
   localparam int FC_ACC_S   = 49;
   localparam int FC_REJ_M   = 7;
   localparam int FC_ACC_M   = 25;
   localparam int FS10_REJ   = 10;
   localparam int FS10_ACC   = 35;
   localparam int FS10_LATE  = 60;
   localparam logic [7:0] CNT_A    = 8'((FC_REJ_A + FC_ACC_A) / 2);
   localparam logic [7:0] CNT_L    = 8'((FC_REJ_L + FC_ACC_L) / 2);
   localparam logic [7:0] CNT_S    = 8'((FC_REJ_S + FC_ACC_S) / 2);
   localparam logic [7:0] CNT_M    = 8'((FC_REJ_M + FC_ACC_M) / 2);
   localparam logic [7:0] CNT_SLOW = 8'((FS10_REJ + FS10_ACC) / 20);
endpackage
`default_nettype wire

/* hw/noise_filter.sv */
/*
 Digital noise filter for one interrupt pin with edge pulses.
 Assumes the pin is synchronous to clk; sample_en paces the count.
*/
`timescale 1ns/1ns
`default_nettype none
module noise_filter #(
   parameter int CNT_W = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             arst_n,
   // Pin and timing
   input  wire logic             pin,
   input  wire logic             sample_en,
   input  wire logic [CNT_W-1:0] thr,
   // Filtered result
   output var  logic             level,
   output var  logic             rise,
   output var  logic             fall
);
   if (CNT_W < 8) begin : g_chk
      $error("noise_filter: CNT_W must be at least 8");
   end

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic             primed_r;
   wire              diff    = pin != level;
   wire [CNT_W-1:0]  cnt_inc = cnt_r + CNT_W'(1);
   wire              hit     = diff && sample_en && (cnt_inc >= thr);

   // Any return to the held level restarts the count
   assign cnt_nxt = (!diff || hit) ? '0 :
                    (sample_en && cnt_inc != '0) ? cnt_inc : cnt_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r    <= '0;
         primed_r <= 1'b0;
         level    <= 1'b1;
         rise     <= 1'b0;
         fall     <= 1'b0;
      end else begin
         primed_r <= primed_r | sample_en;
         cnt_r    <= primed_r ? cnt_nxt : '0;
         if (!primed_r && sample_en) begin
            level <= pin;
         end else if (primed_r && hit) begin
            level <= pin;
         end
         rise <= primed_r && hit && pin;
         fall <= primed_r && hit && !pin;
      end
   end
endmodule
`default_nettype wire

/* hw/fetch_trap.sv */
/*
 Fetch-side fault sources: trap opcode, illegal opcode, forbidden fetch.
 Assumes one fetch strobe per fetched byte from the core.
*/
`timescale 1ns/1ns
`default_nettype none
module fetch_trap #(
   parameter int          AW      = 16,
   parameter logic [15:0] RAM_TOP = 16'h083F
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          arst_n,
   // Fetch from the core
   input  wire logic          fetch_valid,
   input  wire logic [AW-1:0] fetch_addr,
   input  wire logic [7:0]    fetch_data,
   input  wire logic          mem_present,
   input  wire logic          undef_exec,
   // Configuration
   input  wire logic          single_chip,
   input  wire logic          trap_to_reset,
   // Results
   output var  logic [7:0]    opcode,
   output var  logic          sw_irq,
   output var  logic          undef_irq,
   output var  logic          viol_irq,
   output var  logic          viol_rst
);
   if (AW != 16) begin : g_chk
      $error("fetch_trap: AW must be 16");
   end

   wire       in_trap  = fetch_addr <= RAM_TOP;
   wire       blank    = single_chip && !mem_present;
   wire [7:0] op_eff   = blank ? irq_fe_pkg::TRAP_OPCODE : fetch_data;
   wire       is_trap  = fetch_valid && !in_trap &&
                         op_eff == irq_fe_pkg::TRAP_OPCODE;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         opcode    <= 8'h00;
         sw_irq    <= 1'b0;
         undef_irq <= 1'b0;
         viol_irq  <= 1'b0;
         viol_rst  <= 1'b0;
      end else begin
         if (fetch_valid) begin
            opcode <= op_eff;
         end
         sw_irq    <= is_trap;
         undef_irq <= undef_exec && !is_trap;
         viol_irq  <= fetch_valid && in_trap && !trap_to_reset;
         viol_rst  <= fetch_valid && in_trap && trap_to_reset;
      end
   end
endmodule
`default_nettype wire

/* bench/irq_fe_chk.sv */
/*
 Checker on the ports of the interrupt source front end.
 Assumes one clock domain and a bind onto every front end instance.
*/
`timescale 1ns/1ns
`default_nettype none
module irq_fe_chk #(
   parameter logic [15:0] RAM_TOP = 16'h083F
) (
   // Clock and reset
   input wire logic       SYS_CLK,
   input wire logic       ARST_N,
   // Bus handshakes
   input wire logic       ARVALID,
   input wire logic       ARREADY,
   input wire logic       RVALID,
   input wire logic       BVALID,
   input wire logic       BREADY,
   // Fetch side
   input wire logic       FETCH_VALID,
   input wire logic [15:0] FETCH_ADDR,
   input wire logic [7:0] FETCH_DATA,
   input wire logic [7:0] OPCODE_OUT,
   input wire logic       FETCH_MAPPED,
   input wire logic       UNDEF_EXEC,
   input wire logic       SW_TRAP_IRQ,
   input wire logic       ILLEGAL_OPCODE_IRQ,
   input wire logic       FETCH_VIOL_IRQ,
   input wire logic       TRAP_RESET_OUT
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!ARST_N);
   sequence s_ram_fetch;
      FETCH_VALID && FETCH_ADDR <= RAM_TOP;
   endsequence
   sequence s_trap_fetch;
      FETCH_VALID && FETCH_MAPPED && FETCH_ADDR > RAM_TOP &&
      FETCH_DATA == irq_fe_pkg::TRAP_OPCODE;
   endsequence
   a_trap_opcode: assert property (s_trap_fetch |=> SW_TRAP_IRQ)
      else $error("trap opcode raised no trap");
   a_trap_cause: assert property (SW_TRAP_IRQ |-> $past(FETCH_VALID))
      else $error("trap without a fetch");
   a_trap_code: assert property (SW_TRAP_IRQ
      |-> OPCODE_OUT == irq_fe_pkg::TRAP_OPCODE)
      else $error("trap without trap opcode");
   a_viol_kind: assert property (s_ram_fetch |=> FETCH_VIOL_IRQ != TRAP_RESET_OUT)
      else $error("forbidden fetch not answered once");
   a_viol_cause: assert property ((FETCH_VIOL_IRQ || TRAP_RESET_OUT)
      |-> $past(FETCH_VALID && FETCH_ADDR <= RAM_TOP))
      else $error("fetch trap without forbidden fetch");
   a_undef_fast: assert property (UNDEF_EXEC && !FETCH_VALID
      |=> ILLEGAL_OPCODE_IRQ) else $error("illegal opcode late");
   a_undef_cause: assert property (ILLEGAL_OPCODE_IRQ |-> $past(UNDEF_EXEC))
      else $error("illegal opcode without cause");
   a_b_hold: assert property (BVALID && !BREADY |=> BVALID)
      else $error("write response dropped");
   a_r_answer: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
      else $error("read answer late");
endmodule
bind irq_front_end irq_fe_chk #(.RAM_TOP(RAM_TOP)) chk_u (.*);
`default_nettype wire

/* bench/irq_pin_model.sv */
/*
 Model of the external interrupt pin drivers and low-frequency clock.
 Assumes pins change right after a rising edge of clk.
*/
`timescale 1ns/1ns
`default_nettype none
module irq_pin_model (
   // Clock
   input  wire logic       clk,
   // Pins toward the front end
   output var  logic [5:0] pins,
   output var  logic       tick
);
   logic [2:0] div_r = 3'h0;
   // Six pins, falling-edge inputs idle high
   initial pins = 6'h31;
   always @(posedge clk) div_r <= div_r + 3'h1;
   // Free-running low-frequency tick, one per eight cycles
   assign tick = (div_r == 3'h7);
   task pulse(input int i, input int n);
      pins[i] <= ~pins[i];
      repeat (n) @(posedge clk);
      pins[i] <= ~pins[i];
   endtask
   task drive(input int i, input logic v);
      pins[i] <= v;
   endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
/*
 Self-checking bench of the interrupt source front end.
 Assumes the checker binds itself and the pin model drives the pins.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam logic [11:0] A_CTL = {4'h0, irq_fe_pkg::IDX_EXT_CTRL, 2'h0};
   localparam logic [11:0] A_MODE = {4'h0, irq_fe_pkg::IDX_MODE, 2'h0};
   localparam logic [11:0] A_EN = {4'h0, irq_fe_pkg::IDX_ENABLE, 2'h0};
   localparam logic [11:0] A_LAT = {4'h0, irq_fe_pkg::IDX_LATCH, 2'h0};
   localparam logic [11:0] A_SRC = {4'h0, irq_fe_pkg::IDX_SRC_SEL, 2'h0};
   localparam logic [11:0] A_WDG = {4'h0, irq_fe_pkg::IDX_WDOG_CTRL, 2'h0};
   logic SYS_CLK = 1'b0, ARST_N = 1'b0, AWVALID = 1'b0, WVALID = 1'b0;
   logic BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0, UNDEF_EXEC = 1'b0;
   logic FETCH_VALID = 1'b0, FETCH_MAPPED = 1'b0;
   logic [11:0] AWADDR = 12'h000, ARADDR = 12'h000;
   logic [31:0] WDATA = 32'h0, RDATA, rdv;
   logic [3:0]  WSTRB = 4'hF;
   logic [15:0] FETCH_ADDR = 16'h0000;
   logic [7:0]  FETCH_DATA = 8'h00, OPCODE_OUT;
   logic [5:0]  EXT_IRQ_ACK = 6'h00, EXT_PIN, EXT_IRQ_REQ;
   logic [1:0]  BRESP, RRESP, rsp;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SW_TRAP_IRQ;
   logic ILLEGAL_OPCODE_IRQ, FETCH_VIOL_IRQ, TRAP_RESET_OUT;
   logic PIN_ZERO_IS_IRQ, LOW_FREQ_TICK, aw, w;
   int failures = 0, checks_done = 0, cyc = 0;
   irq_front_end dut_u (.*);
   irq_pin_model pins_u (.clk(SYS_CLK), .pins(EXT_PIN), .tick(LOW_FREQ_TICK));
   always #2 SYS_CLK = ~SYS_CLK;
   // ********
   // Bus, fetch and compare tasks
   // ********
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge SYS_CLK);
      AWADDR <= a; WDATA <= d; AWVALID <= 1'b1; WVALID <= 1'b1;
      aw = 1'b1; w = 1'b1;
      while (aw || w) begin
         @(posedge SYS_CLK);
         if (aw && AWREADY) begin aw = 1'b0; AWVALID <= 1'b0; end
         if (w && WREADY) begin w = 1'b0; WVALID <= 1'b0; end
      end
      while (!BVALID) @(posedge SYS_CLK);
      BREADY <= 1'b1;
      @(posedge SYS_CLK);
      rsp = BRESP; BREADY <= 1'b0;
   endtask
   task rd(input logic [11:0] a);
      @(posedge SYS_CLK);
      ARADDR <= a; ARVALID <= 1'b1;
      do @(posedge SYS_CLK); while (!ARREADY);
      ARVALID <= 1'b0;
      do @(posedge SYS_CLK); while (!RVALID);
      RREADY <= 1'b1;
      @(posedge SYS_CLK);
      rdv = RDATA; rsp = RRESP; RREADY <= 1'b0;
   endtask
   task fetch(input logic [15:0] a, input logic [7:0] d,
              input logic m, v, u, input logic [11:0] e);
      @(posedge SYS_CLK);
      FETCH_VALID <= v; FETCH_ADDR <= a; FETCH_DATA <= d;
      FETCH_MAPPED <= m; UNDEF_EXEC <= u;
      @(posedge SYS_CLK);
      FETCH_VALID <= 1'b0; UNDEF_EXEC <= 1'b0;
      @(posedge SYS_CLK);
      chk({OPCODE_OUT, SW_TRAP_IRQ, ILLEGAL_OPCODE_IRQ, FETCH_VIOL_IRQ,
           TRAP_RESET_OUT}, e);
   endtask
   task ftest(input int i, input logic [7:0] c, input int n, input logic e);
      wr(A_EN, 32'h0);
      wr(A_CTL, c);
      wr(A_EN, 32'hBF);
      repeat (70) @(posedge SYS_CLK);
      wr(A_LAT, 32'h3F);
      pins_u.pulse(i, n);
      repeat (300) @(posedge SYS_CLK);
      rd(A_LAT);
      chk(rdv[i], e);
   endtask
   task close_out;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge SYS_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin failures++; close_out(); end
   end
   // ********
   // Tests
   // ********
   initial begin
      repeat (2) @(posedge SYS_CLK);
      ARST_N <= 1'b1;
      rd(A_CTL); chk(rdv, 32'h0);
      chk(PIN_ZERO_IS_IRQ, 1'b0);
      rd(A_MODE); chk(rdv, 32'h2);
      rd(12'h0F4); chk(rdv, 32'h0); chk(rsp, 2'h0);
      rd(12'h0EC); chk(rdv, 32'h31);
      wr(12'h100, 32'hFF); chk(rsp, 2'h2);
      rd(12'h100); chk(rsp, 2'h2);
      wr(A_CTL, 32'hFF); chk(rsp, 2'h0);
      rd(A_CTL); chk(rdv, 32'hFE);
      wr(A_CTL, 32'h30); repeat (40) @(posedge SYS_CLK);
      rd(A_LAT); chk(rdv[4], 1'b0);
      WSTRB <= 4'h0; wr(A_CTL, 32'hFF); WSTRB <= 4'hF;
      rd(A_CTL); chk(rdv, 32'h30);
      $display("register test done");
      for (int c = 0; c < 5; c++) begin
         wr(A_SRC, c == 4);
         wr(A_CTL, (c % 4) << 4);
         pins_u.drive(4, 1'b0); repeat (40) @(posedge SYS_CLK);
         wr(A_LAT, 32'h3F);
         pins_u.drive(4, 1'b1); repeat (40) @(posedge SYS_CLK);
         rd(A_LAT); chk(rdv[4], c == 0 || c == 2 || c == 3);
         wr(A_LAT, 32'h3F);
         pins_u.drive(4, 1'b0); repeat (40) @(posedge SYS_CLK);
         rd(A_LAT); chk(rdv[4], c > 0 && c < 4);
      end
      $display("trigger test done");
      fetch(16'h1000, 8'hFF, 1'b1, 1'b1, 1'b0, 12'hFF8);
      fetch(16'h1000, 8'h12, 1'b0, 1'b1, 1'b0, 12'hFF8);
      fetch(16'h0100, 8'h12, 1'b1, 1'b1, 1'b0, 12'h122);
      fetch(16'h0100, 8'h34, 1'b1, 1'b0, 1'b1, 12'h124);
      wr(A_WDG, 32'h1);
      fetch(16'h0010, 8'h12, 1'b1, 1'b1, 1'b0, 12'h121);
      $display("fetch test done");
      ftest(0, 8'h00, 20, 1'b0);
      ftest(0, 8'h40, 1, 1'b0);
      ftest(0, 8'h40, 7, 1'b1);
      chk({PIN_ZERO_IS_IRQ, EXT_IRQ_REQ[0]}, 2'h3);
      EXT_IRQ_ACK <= 6'h01;
      @(posedge SYS_CLK);
      EXT_IRQ_ACK <= 6'h00;
      @(posedge SYS_CLK);
      chk(EXT_IRQ_REQ[0], 1'b0);
      ftest(5, 8'h40, 1, 1'b0);
      ftest(5, 8'h40, 7, 1'b1);
      ftest(1, 8'h40, 62, 1'b0);
      ftest(1, 8'h40, 193, 1'b1);
      ftest(1, 8'hC0, 14, 1'b0);
      ftest(1, 8'hC0, 49, 1'b1);
      ftest(2, 8'h40, 6, 1'b0);
      ftest(2, 8'h40, 25, 1'b1);
      ftest(3, 8'h48, 25, 1'b1);
      wr(A_EN, 32'h0);
      wr(A_MODE, 32'h3);
      ftest(2, 8'h40, 7, 1'b0);
      ftest(2, 8'h40, 28, 1'b1);
      $display("filter test done");
      close_out();
   end
endmodule
`default_nettype wire
